// ===== edi_apb_model.sv
module edi_apb_model (
    // clock
    input wire logic aclk,
    // apb master side
    output edi_pkg::edi_apb_req_t req,
    input wire edi_pkg::edi_apb_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // one transfer; ok stays low when the slave never answers
    task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d,
        input logic s, output logic ok);
        int k;
        @(posedge aclk);
        req <= '{1'b1, 1'b0, w, s, a, d};
        @(posedge aclk);
        req.penable <= 1'b1;
        for (k = 0; k < 64 && rsp.pready !== 1'b1; k++)
            @(posedge aclk);
        ok = k < 64;
        // released lines carry junk, never the last value
        req <= '{1'b0, 1'b0, ~w, ~s, ~a, ~d};
    endtask
endmodule

// ===== edi_debug_port.sv
// Behaviour
// - debug slave port: 32-bit data, word address bits 12:2, stalls and aborts
// - address bit 12 low selects the debug register area
// - address bit 12 high selects the performance-monitor area
// - requester supplies access source flag with every transfer
// - secure invasive needs both enables; non-secure invasive needs invasive enable
// - non-invasive permitted by either enable; secure also needs a secure enable
// - invasive enable low: halt mode reads 00, halt requests ignored
// - detected enable combination visible in status bits and authentication register
// - external halt request enters debug state with entry method 0100
// - acknowledge high in debug state or while force acknowledge bit set
// - entry complete only after barrier and all earlier memory accesses finish
// - receive pending equals receive full flag, cleared by processor read
// - transmit free equals inverted transmit full flag, cleared by processor write
// - processor reaches same registers by loads and stores on its memory bus
// - outstanding asynchronous aborts recognised before debug state
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
module edi_debug_port (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // debug apb slave port
    input wire edi_pkg::edi_apb_req_t apb_req,
    output edi_pkg::edi_apb_rsp_t apb_rsp,
    // processor memory-bus slave, axi4-lite
    input wire edi_pkg::edi_axi_req_t axi_req,
    output edi_pkg::edi_axi_rsp_t axi_rsp,
    // authentication pins
    input wire logic secure_invasive_enable,
    input wire logic invasive_enable,
    input wire logic secure_noninvasive_enable,
    input wire logic noninvasive_enable,
    // halt handshake and core status
    input wire logic external_halt_request,
    input wire logic core_mem_idle,
    input wire logic async_abort_pending,
    output logic halt_acknowledge,
    output logic entry_complete,
    // comms channel
    output logic comms_receive_pending,
    output logic comms_transmit_free,
    // system address straps
    input wire logic [19:0] rom_table_base,
    input wire logic [19:0] self_offset
);

    edi_pkg::edi_state_t s;
    edi_pkg::edi_state_t n;
    logic apb_go;
    logic axi_wr_go;
    logic axi_rd_go;
    logic acc_on;
    logic acc_wr;
    logic acc_dbg;
    logic acc_err;
    logic [12:0] acc_addr;
    logic [31:0] acc_wdata;
    logic [31:0] acc_mask;
    logic [31:0] acc_rdata;
    logic [31:0] wval;
    edi_pkg::edi_reg_t acc_rid;

    // ****************************************
    // helpers
    // ****************************************
    function automatic edi_pkg::edi_reg_t decode(input logic [12:0] a);
        edi_pkg::edi_reg_t r;
        r = edi_pkg::REG_NONE;
        unique case ({a[12:2], 2'b00})
            edi_pkg::OFF_RX_DATA: r = edi_pkg::REG_RX_DATA;
            edi_pkg::OFF_STAT: r = edi_pkg::REG_STAT;
            edi_pkg::OFF_TX_DATA: r = edi_pkg::REG_TX_DATA;
            edi_pkg::OFF_RUN_CTRL: r = edi_pkg::REG_RUN_CTRL;
            edi_pkg::OFF_ROM_BASE: r = edi_pkg::REG_ROM_BASE;
            edi_pkg::OFF_SELF_OFFSET: r = edi_pkg::REG_SELF_OFFSET;
            edi_pkg::OFF_AUTH_STATUS: r = edi_pkg::REG_AUTH;
            edi_pkg::OFF_PERF_CYCLES: r = edi_pkg::REG_PERF_CYCLES;
            edi_pkg::OFF_PERF_CTRL: r = edi_pkg::REG_PERF_CTRL;
            default: r = edi_pkg::REG_NONE;
        endcase
        return r;
    endfunction

    function automatic logic [3:0] permissions(input logic [3:0] p);
        logic [3:0] q;
        q = '0;
        q[edi_pkg::PERM_NS_INV] = p[edi_pkg::PIN_INV];
        q[edi_pkg::PERM_SEC_INV] = p[edi_pkg::PIN_INV] & p[edi_pkg::PIN_SPI];
        q[edi_pkg::PERM_NS_NONINV] = p[edi_pkg::PIN_NI] | p[edi_pkg::PIN_INV];
        q[edi_pkg::PERM_SEC_NONINV] = q[edi_pkg::PERM_NS_NONINV]
            & (p[edi_pkg::PIN_SPI] | p[edi_pkg::PIN_SPNI]);
        return q;
    endfunction

    function automatic logic [31:0] read_word(input edi_pkg::edi_state_t c,
                                              input edi_pkg::edi_reg_t r);
        logic [31:0] v;
        v = '0;
        unique case (r)
            edi_pkg::REG_RX_DATA: v = c.rx_data;
            edi_pkg::REG_TX_DATA: v = c.tx_data;
            edi_pkg::REG_STAT:
            begin
                v[edi_pkg::STAT_RX_FULL] = c.rx_full;
                v[edi_pkg::STAT_TX_FULL] = ~c.tx_free;
                v[edi_pkg::STAT_SEC_NONINV_OFF] = ~c.perm[edi_pkg::PERM_SEC_NONINV];
                v[edi_pkg::STAT_SEC_INV_OFF] = ~c.perm[edi_pkg::PERM_SEC_INV];
                // mode bits read as zero while invasive debug is off
                v[edi_pkg::STAT_HALT_MODE +: 2] = c.halt_mode
                    & {2{c.pin_s2[edi_pkg::PIN_INV]}};
                v[edi_pkg::STAT_FORCE_ACK] = c.force_ack;
                v[edi_pkg::STAT_METHOD +: 4] = c.method;
                v[edi_pkg::STAT_HALTED] = (c.phase == edi_pkg::PH_HALTED);
            end
            edi_pkg::REG_ROM_BASE: v = {c.rom_s2, 12'h000};
            edi_pkg::REG_SELF_OFFSET: v = {c.self_s2, 12'h000};
            edi_pkg::REG_AUTH: v = {23'h000000, c.last_src, 4'h0, c.perm};
            edi_pkg::REG_PERF_CYCLES: v = c.cycles;
            edi_pkg::REG_PERF_CTRL: v = {31'h00000000, c.perf_en};
            default: v = '0;
        endcase
        return v;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        n = s;
        n.pin_s1 = {external_halt_request, noninvasive_enable, secure_noninvasive_enable,
            invasive_enable, secure_invasive_enable};
        n.pin_s2 = s.pin_s1;
        n.rom_s1 = rom_table_base;
        n.rom_s2 = s.rom_s1;
        n.self_s1 = self_offset;
        n.self_s2 = s.self_s1;
        n.perm = permissions(s.pin_s2[3:0]);

        // counters only run where non-invasive observation is allowed
        if (s.perf_en && s.perm[edi_pkg::PERM_NS_NONINV])
        begin
            n.cycles = s.cycles + 32'h00000001;
        end

        // apb: one wait state, then a one-cycle pready
        apb_go = apb_req.psel & apb_req.penable & ~s.apb.pready;
        n.apb.pready = apb_go;
        n.apb.pslverr = 1'b0;

        // axi4-lite channels, address and data taken in either order
        if (s.axi.bvalid && axi_req.bready)
        begin
            n.axi.bvalid = 1'b0;
        end
        if (s.axi.rvalid && axi_req.rready)
        begin
            n.axi.rvalid = 1'b0;
            n.ar_held = 1'b0;
        end
        if (axi_req.awvalid && s.axi.awready)
        begin
            n.aw_held = 1'b1;
            n.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s.axi.wready)
        begin
            n.w_held = 1'b1;
            n.wdata = axi_req.wdata;
            n.wstrb = axi_req.wstrb;
        end
        if (axi_req.arvalid && s.axi.arready)
        begin
            n.ar_held = 1'b1;
            n.araddr = axi_req.araddr;
        end

        // one register access per cycle, the debug port has priority
        axi_wr_go = ~apb_go & s.aw_held & s.w_held & ~s.axi.bvalid;
        axi_rd_go = ~apb_go & ~axi_wr_go & s.ar_held & ~s.axi.rvalid;
        acc_on = apb_go | axi_wr_go | axi_rd_go;
        acc_dbg = apb_go;
        acc_wr = apb_go ? apb_req.pwrite : axi_wr_go;
        acc_addr = apb_go ? apb_req.debug_port_address : (axi_wr_go ? s.awaddr : s.araddr);
        acc_wdata = apb_go ? apb_req.pwdata : s.wdata;
        acc_mask = apb_go ? 32'hffffffff : {{8{s.wstrb[3]}}, {8{s.wstrb[2]}},
            {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
        acc_rid = decode(acc_addr);
        acc_err = acc_on & (acc_rid == edi_pkg::REG_NONE);
        acc_rdata = read_word(s, acc_rid);
        wval = (acc_rdata & ~acc_mask) | (acc_wdata & acc_mask);

        if (apb_go)
        begin
            n.last_src = apb_req.access_source_flag;
        end

        if (acc_on && acc_wr && !acc_err)
        begin
            unique case (acc_rid)
                edi_pkg::REG_RX_DATA:
                    if (acc_dbg)
                    begin
                        n.rx_data = wval;
                        n.rx_full = 1'b1;
                    end
                edi_pkg::REG_TX_DATA:
                    if (!acc_dbg)
                    begin
                        n.tx_data = wval;
                        n.tx_free = 1'b0;
                    end
                edi_pkg::REG_STAT:
                begin
                    n.force_ack = wval[edi_pkg::STAT_FORCE_ACK];
                    n.halt_mode = wval[edi_pkg::STAT_HALT_MODE +: 2];
                end
                edi_pkg::REG_RUN_CTRL:
                    if (wval[0] && s.phase == edi_pkg::PH_HALTED)
                    begin
                        n.phase = edi_pkg::PH_RUN;
                        n.done = 1'b0;
                    end
                edi_pkg::REG_PERF_CYCLES: n.cycles = wval;
                edi_pkg::REG_PERF_CTRL: n.perf_en = wval[0];
                default:
                begin
                end
            endcase
        end
        else if (acc_on && !acc_wr && !acc_err)
        begin
            // a read by the far side of the channel empties it
            if (acc_rid == edi_pkg::REG_RX_DATA && !acc_dbg)
            begin
                n.rx_full = 1'b0;
            end
            if (acc_rid == edi_pkg::REG_TX_DATA && acc_dbg)
            begin
                n.tx_free = 1'b1;
            end
        end

        if (apb_go)
        begin
            n.apb.prdata = acc_wr ? 32'h00000000 : acc_rdata;
            n.apb.pslverr = acc_err;
        end
        if (axi_wr_go)
        begin
            n.axi.bvalid = 1'b1;
            n.axi.bresp = acc_err ? edi_pkg::RESP_SLVERR : edi_pkg::RESP_OKAY;
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
        end
        if (axi_rd_go)
        begin
            n.axi.rvalid = 1'b1;
            n.axi.rdata = acc_rdata;
            n.axi.rresp = acc_err ? edi_pkg::RESP_SLVERR : edi_pkg::RESP_OKAY;
        end
        n.axi.awready = ~n.aw_held;
        n.axi.wready = ~n.w_held;
        n.axi.arready = ~n.ar_held;

        // halt entry; the request is trusted to stay up until acknowledged
        unique case (s.phase)
            edi_pkg::PH_RUN:
                if (s.pin_s2[edi_pkg::PIN_HALT] && s.pin_s2[edi_pkg::PIN_INV])
                begin
                    n.phase = edi_pkg::PH_DRAIN;
                end
            edi_pkg::PH_DRAIN:
                if (!s.pin_s2[edi_pkg::PIN_INV])
                begin
                    n.phase = edi_pkg::PH_RUN;
                end
                else if (core_mem_idle && !async_abort_pending)
                begin
                    n.phase = edi_pkg::PH_HALTED;
                    n.method = edi_pkg::METHOD_EXT_HALT;
                    n.done = 1'b1;
                end
            edi_pkg::PH_HALTED:
            begin
            end
        endcase
        n.halt_ack = (n.phase == edi_pkg::PH_HALTED) | n.force_ack;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= edi_pkg::STATE_RESET;
        end
        else
        begin
            s <= n;
        end
    end

    assign apb_rsp = s.apb;
    assign axi_rsp = s.axi;
    assign halt_acknowledge = s.halt_ack;
    assign entry_complete = s.done;
    assign comms_receive_pending = s.rx_full;
    assign comms_transmit_free = s.tx_free;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_apb_stall;
        apb_go |=> apb_rsp.pready ##1 !apb_rsp.pready;
    endproperty
    a_apb_stall: assert property (p_apb_stall) else $error("apb wait state wrong");

    property p_apb_abort;
        apb_go && acc_err |=> apb_rsp.pready && apb_rsp.pslverr;
    endproperty
    a_apb_abort: assert property (p_apb_abort) else $error("no abort on unmapped");

    property p_debug_area;
        apb_go && !apb_req.debug_port_address[edi_pkg::AREA_BIT]
            |-> !(acc_rid inside {edi_pkg::REG_PERF_CYCLES, edi_pkg::REG_PERF_CTRL});
    endproperty
    a_debug_area: assert property (p_debug_area) else $error("bit12 low hit perf area");

    property p_perf_area;
        apb_go && apb_req.debug_port_address[edi_pkg::AREA_BIT] && !acc_err
            |-> acc_rid inside {edi_pkg::REG_PERF_CYCLES, edi_pkg::REG_PERF_CTRL};
    endproperty
    a_perf_area: assert property (p_perf_area) else $error("bit12 high missed perf area");

    property p_source;
        apb_go |=> s.last_src == $past(apb_req.access_source_flag);
    endproperty
    a_source: assert property (p_source) else $error("access source not kept");

    property p_sec_inv;
        s.perm[edi_pkg::PERM_SEC_INV]
            |-> $past(s.pin_s2[edi_pkg::PIN_INV] && s.pin_s2[edi_pkg::PIN_SPI]);
    endproperty
    a_sec_inv: assert property (p_sec_inv) else $error("secure invasive wrongly on");

    property p_ns_noninv;
        ##1 s.perm[edi_pkg::PERM_NS_NONINV]
            == $past(s.pin_s2[edi_pkg::PIN_NI] || s.pin_s2[edi_pkg::PIN_INV]);
    endproperty
    a_ns_noninv: assert property (p_ns_noninv) else $error("non-invasive perm wrong");

    property p_ignore_halt;
        s.phase == edi_pkg::PH_RUN && !s.pin_s2[edi_pkg::PIN_INV] |=> s.phase == edi_pkg::PH_RUN;
    endproperty
    a_ignore_halt: assert property (p_ignore_halt) else $error("halt taken while off");

    property p_auth_read;
        apb_go && !acc_wr && acc_rid == edi_pkg::REG_AUTH |=> apb_rsp.prdata[3:0] == $past(s.perm);
    endproperty
    a_auth_read: assert property (p_auth_read) else $error("auth status wrong");

    property p_method;
        s.phase != edi_pkg::PH_HALTED ##1 s.phase == edi_pkg::PH_HALTED
            |-> s.method == edi_pkg::METHOD_EXT_HALT && halt_acknowledge;
    endproperty
    a_method: assert property (p_method) else $error("entry method or ack wrong");

    property p_ack;
        s.phase == edi_pkg::PH_HALTED || s.force_ack |-> halt_acknowledge;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge missing");

    property p_done;
        $rose(entry_complete) |-> $past(core_mem_idle) && !$past(async_abort_pending);
    endproperty
    a_done: assert property (p_done) else $error("entry complete too early");

    property p_rx;
        apb_go && acc_wr && acc_rid == edi_pkg::REG_RX_DATA |=> comms_receive_pending;
    endproperty
    a_rx: assert property (p_rx) else $error("receive pending not set");

    property p_tx;
        axi_wr_go && acc_rid == edi_pkg::REG_TX_DATA |=> !comms_transmit_free;
    endproperty
    a_tx: assert property (p_tx) else $error("transmit free not cleared");

    property p_axi_write;
        axi_req.awvalid && axi_req.wvalid && axi_rsp.awready && axi_rsp.wready
            |-> ##[1:8] axi_rsp.bvalid;
    endproperty
    a_axi_write: assert property (p_axi_write) else $error("axi write not answered");

    property p_abort_first;
        s.phase == edi_pkg::PH_DRAIN && async_abort_pending |=> s.phase != edi_pkg::PH_HALTED;
    endproperty
    a_abort_first: assert property (p_abort_first) else $error("halted before abort");

    c_halt: cover property (s.phase == edi_pkg::PH_DRAIN ##[1:8] s.phase == edi_pkg::PH_HALTED);
    c_apb_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
    c_rx_trip: cover property (comms_receive_pending ##[1:20] !comms_receive_pending);
    c_axi_read: cover property (axi_rsp.rvalid && axi_req.rready);

endmodule

// ===== edi_pkg.sv
package edi_pkg;

    // ****************************************
    // address map
    // ****************************************
    localparam int AREA_BIT = 12;
    localparam logic [12:0] OFF_RX_DATA = 13'h0080;
    localparam logic [12:0] OFF_STAT = 13'h0088;
    localparam logic [12:0] OFF_TX_DATA = 13'h008c;
    localparam logic [12:0] OFF_RUN_CTRL = 13'h0090;
    localparam logic [12:0] OFF_ROM_BASE = 13'h00a0;
    localparam logic [12:0] OFF_SELF_OFFSET = 13'h00a4;
    localparam logic [12:0] OFF_AUTH_STATUS = 13'h0fb8;
    localparam logic [12:0] OFF_PERF_CYCLES = 13'h107c;
    localparam logic [12:0] OFF_PERF_CTRL = 13'h1e04;

    // ****************************************
    // field positions and codes
    // ****************************************
    localparam int STAT_RX_FULL = 30;
    localparam int STAT_TX_FULL = 29;
    localparam int STAT_SEC_NONINV_OFF = 17;
    localparam int STAT_SEC_INV_OFF = 16;
    localparam int STAT_HALT_MODE = 14;
    localparam int STAT_FORCE_ACK = 10;
    localparam int STAT_METHOD = 2;
    localparam int STAT_HALTED = 0;
    localparam int AUTH_SOURCE = 8;
    localparam logic [3:0] METHOD_EXT_HALT = 4'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // synchronised pin vector and permission vector positions
    localparam int PIN_SPI = 0;
    localparam int PIN_INV = 1;
    localparam int PIN_SPNI = 2;
    localparam int PIN_NI = 3;
    localparam int PIN_HALT = 4;
    localparam int PERM_NS_NONINV = 0;
    localparam int PERM_NS_INV = 1;
    localparam int PERM_SEC_NONINV = 2;
    localparam int PERM_SEC_INV = 3;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {REG_NONE, REG_RX_DATA, REG_STAT, REG_TX_DATA, REG_RUN_CTRL,
        REG_ROM_BASE, REG_SELF_OFFSET, REG_AUTH, REG_PERF_CYCLES, REG_PERF_CTRL} edi_reg_t;
    typedef enum logic [1:0] {PH_RUN, PH_DRAIN, PH_HALTED} edi_phase_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic access_source_flag;
        logic [12:0] debug_port_address;
        logic [31:0] pwdata;
    } edi_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } edi_apb_rsp_t;

    typedef struct packed {
        logic awvalid;
        logic [12:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [12:0] araddr;
        logic rready;
    } edi_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } edi_axi_rsp_t;

    typedef struct packed {
        logic [4:0] pin_s1;
        logic [4:0] pin_s2;
        logic [19:0] rom_s1;
        logic [19:0] rom_s2;
        logic [19:0] self_s1;
        logic [19:0] self_s2;
        logic [3:0] perm;
        edi_phase_t phase;
        logic force_ack;
        logic [1:0] halt_mode;
        logic [3:0] method;
        logic rx_full;
        logic tx_free;
        logic [31:0] rx_data;
        logic [31:0] tx_data;
        logic perf_en;
        logic [31:0] cycles;
        logic last_src;
        logic halt_ack;
        logic done;
        logic aw_held;
        logic w_held;
        logic ar_held;
        logic [12:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [12:0] araddr;
        edi_apb_rsp_t apb;
        edi_axi_rsp_t axi;
    } edi_state_t;

    localparam edi_state_t STATE_RESET = '{phase: PH_RUN, tx_free: 1'b1, default: '0};

endpackage

// ===== external_debug_interface_test.sv
module external_debug_interface_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] r; logic [31:0] d; logic c;} edi_exp_t;
    logic aclk, aresetn, hrq, idle, abt, ack, cpl, crx, ctx, s, ok;
    logic [3:0] au, pm;
    logic [19:0] rom, slf;
    logic [31:0] v;
    edi_pkg::edi_apb_req_t preq;
    edi_pkg::edi_apb_rsp_t prsp;
    edi_pkg::edi_axi_req_t areq;
    edi_pkg::edi_axi_rsp_t arsp;
    edi_exp_t pq[$], aq[$], m;
    int failures, check_count, i;

    edi_apb_model dbg (.aclk(aclk), .req(preq), .rsp(prsp));
    edi_debug_port dut (.aclk(aclk), .aresetn(aresetn), .apb_req(preq), .apb_rsp(prsp),
        .axi_req(areq), .axi_rsp(arsp), .secure_invasive_enable(au[3]),
        .invasive_enable(au[2]), .secure_noninvasive_enable(au[1]),
        .noninvasive_enable(au[0]), .external_halt_request(hrq), .core_mem_idle(idle),
        .async_abort_pending(abt), .halt_acknowledge(ack), .entry_complete(cpl),
        .comms_receive_pending(crx), .comms_transmit_free(ctx), .rom_table_base(rom),
        .self_offset(slf));

    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // ****************
    // tasks
    // ****************
    task automatic cmp_word(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic cmp_pin(input string n, input logic x, input logic g);
        cmp_word(n, {31'h0, x}, {31'h0, g});
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic hang;
        failures++;
        give_verdict();
    endtask
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d,
        input logic [31:0] x, input logic er);
        pq.push_back('{er ? 2'h2 : 2'h0, w ? 32'h0 : x, !er});
        dbg.xfer(w, a, d, s, ok);
        if (!ok) hang();
    endtask
    task automatic axi(input logic w, input logic [12:0] a, input logic [31:0] d,
        input logic [1:0] r);
        int k;
        aq.push_back('{r, d, !w && r == 2'h0});
        @(posedge aclk);
        areq <= '{w, a, w, d, 4'hf, w, !w, a, !w};
        for (k = 0; k < 64; k++)
        begin
            @(posedge aclk);
            if (arsp.awready === 1'b1) areq.awvalid <= 1'b0;
            if (arsp.wready === 1'b1) areq.wvalid <= 1'b0;
            if (arsp.arready === 1'b1) areq.arvalid <= 1'b0;
            if (arsp.bvalid === 1'b1 || arsp.rvalid === 1'b1) break;
        end
        areq.bready <= 1'b0;
        areq.rready <= 1'b0;
        if (k == 64) hang();
    endtask
    function automatic logic [3:0] perm(input logic [3:0] p);
        perm = {p[3] & p[2], (p[2] | p[0]) & (p[3] | p[1]), p[2], p[2] | p[0]};
    endfunction

    // results are checked as they appear, oldest note first
    always @(posedge aclk)
    begin
        if (prsp.pready === 1'b1)
        begin
            m = pq.pop_front();
            cmp_word("apb resp", {30'h0, m.r}, {30'h0, prsp.pslverr, 1'b0});
            if (m.c) cmp_word("apb data", m.d, prsp.prdata);
        end
        if ((areq.bready && arsp.bvalid === 1'b1) || (areq.rready && arsp.rvalid === 1'b1))
        begin
            m = aq.pop_front();
            cmp_word("axi resp", {30'h0, m.r}, {30'h0, areq.bready ? arsp.bresp : arsp.rresp});
            if (m.c) cmp_word("axi data", m.d, arsp.rdata);
        end
    end

    // ****************
    // tests
    // ****************
    initial
    begin
        {aresetn, hrq, abt, s, au, areq, failures, check_count} = '0;
        idle = 1'b1;
        v = $urandom(45);
        rom = v[19:0];
        slf = v[31:12];
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(negedge aclk);
        cmp_pin("ack", 1'b0, ack);
        cmp_pin("rx", 1'b0, crx);
        cmp_pin("tx", 1'b1, ctx);
        apb(0, edi_pkg::OFF_ROM_BASE, 0, {rom, 12'h0}, 0);
        apb(0, edi_pkg::OFF_SELF_OFFSET, 0, {slf, 12'h0}, 0);
        $display("test reset done");
        for (i = 0; i < 16; i++)
        begin
            v = $urandom;
            au <= i[3:0];
            s <= v[0];
            pm = perm(i[3:0]);
            repeat (4) @(posedge aclk);
            apb(1, edi_pkg::OFF_STAT, 32'h0000c000, 0, 0);
            apb(0, edi_pkg::OFF_STAT, 0, {14'h0, ~pm[2], ~pm[3], {2{pm[1]}}, 14'h0}, 0);
            apb(0, edi_pkg::OFF_AUTH_STATUS, 0, {23'h0, s, 4'h0, pm}, 0);
        end
        $display("test auth done");
        v = $urandom;
        apb(1, edi_pkg::OFF_PERF_CTRL, 0, 0, 0);
        apb(1, edi_pkg::OFF_PERF_CYCLES, v, 0, 0);
        apb(0, edi_pkg::OFF_PERF_CYCLES, 0, v, 0);
        apb(0, 13'h007c, 0, 0, 1);
        apb(1, 13'h1088, v, 0, 1);
        axi(0, 13'h0ffc, 0, 2'h2);
        apb(1, edi_pkg::OFF_RX_DATA, v, 0, 0);
        repeat (2) @(negedge aclk);
        cmp_pin("rx", 1'b1, crx);
        axi(0, edi_pkg::OFF_RX_DATA, v, 2'h0);
        repeat (2) @(negedge aclk);
        cmp_pin("rx", 1'b0, crx);
        axi(1, edi_pkg::OFF_TX_DATA, ~v, 2'h0);
        repeat (2) @(negedge aclk);
        cmp_pin("tx", 1'b0, ctx);
        apb(0, edi_pkg::OFF_TX_DATA, 0, ~v, 0);
        repeat (2) @(negedge aclk);
        cmp_pin("tx", 1'b1, ctx);
        $display("test comms done");
        @(posedge aclk);
        idle <= 1'b0;
        hrq <= 1'b1;
        repeat (12) @(negedge aclk);
        cmp_pin("ack", 1'b0, ack);
        @(posedge aclk);
        idle <= 1'b1;
        abt <= 1'b1;
        repeat (12) @(negedge aclk);
        cmp_pin("ack", 1'b0, ack);
        @(posedge aclk);
        abt <= 1'b0;
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(negedge aclk);
        if (i == 20) hang();
        cmp_pin("done", 1'b1, cpl);
        @(posedge aclk);
        hrq <= 1'b0;
        apb(0, edi_pkg::OFF_STAT, 0, 32'h0000c011, 0);
        apb(1, edi_pkg::OFF_RUN_CTRL, 1, 0, 0);
        repeat (2) @(negedge aclk);
        cmp_pin("ack", 1'b0, ack);
        apb(1, edi_pkg::OFF_STAT, 32'h0000c400, 0, 0);
        repeat (2) @(negedge aclk);
        cmp_pin("ack", 1'b1, ack);
        apb(1, edi_pkg::OFF_STAT, 32'h0000c000, 0, 0);
        @(posedge aclk);
        au[2] <= 1'b0;
        hrq <= 1'b1;
        repeat (20) @(negedge aclk);
        cmp_pin("ack", 1'b0, ack);
        $display("test halt done");
        give_verdict();
    end
endmodule
